// file: core/mab_core.sv
// core: alu, multiply, branch and io-space access execution unit
`timescale 1ns/1ps
`default_nettype none
module mab_core
	import mab_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	// clock and control
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// instruction stream
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	input  wire logic [15:0] instr_next,
	output logic             ready_q,
	output logic [15:0]      pc_q,
	// core status
	output logic [7:0]       sreg_q,
	// io and data space
	output var mab_bus_t     dbus_q,
	input  wire logic [7:0]  dbus_rdata,
	// internal status flags
	input  wire logic [7:0]  flag_evt,
	output logic [7:0]       flags_q
);
	localparam int SPW = $clog2(STACK_DEPTH);

	logic [7:0]     rf_q [32];
	logic [15:0]    stk_q [STACK_DEPTH];
	logic [SPW-1:0] sp_q;
	mab_state_t     st_q;
	logic [1:0]     wait_q;
	logic           rd_load_q, rd_skip_q, rd_hi_q, rd_two_q, rd_int_q;
	logic [4:0]     rd_reg_q;
	logic [2:0]     rd_bit_q;

	logic           take, nx_two, skip_hit;
	logic [15:0]    w, rel_tgt, ptr, wv, wr;
	logic [4:0]     rd5, rr5, rdh, wa;
	logic [7:0]     k8, rdv, d0, d1, sr_d, fclr;
	logic           we0, we1;
	logic [4:0]     a0, a1;
	logic [15:0]    pc_d, push_v;
	logic [2:0]     cyc;
	mab_bus_t       bus_d;
	logic           rd_go, rd_load, rd_skip, rd_int, push, pop;
	mab_alu_t       al;
	logic [16:0]    mp;
	logic           op_byte, op_minus_const_with_carry, op_logic, op_word, op_mul;
	logic           op_relative_subroutine_jump, op_pointer_jump, op_pointer_subroutine_jump, op_jmp, op_call;
	logic           op_compare_equal_skip, op_bitw, op_port, op_ds;

	function automatic mab_alu_t add8(input logic [7:0] x, y,
			input logic ci);
		mab_alu_t r;
		r.res = x + y + {7'h00, ci};
		r.c = (x[7] & y[7]) | (y[7] & ~r.res[7]) | (~r.res[7] & x[7]);
		r.h = (x[3] & y[3]) | (y[3] & ~r.res[3]) | (~r.res[3] & x[3]);
		r.v = (x[7] & y[7] & ~r.res[7]) | (~x[7] & ~y[7] & r.res[7]);
		return r;
	endfunction : add8

	function automatic mab_alu_t sub8(input logic [7:0] x, y,
			input logic ci);
		mab_alu_t r;
		r.res = x - y - {7'h00, ci};
		r.c = (~x[7] & y[7]) | (y[7] & r.res[7]) | (r.res[7] & ~x[7]);
		r.h = (~x[3] & y[3]) | (y[3] & r.res[3]) | (r.res[3] & ~x[3]);
		r.v = (x[7] & ~y[7] & ~r.res[7]) | (~x[7] & y[7] & r.res[7]);
		return r;
	endfunction : sub8

	function automatic logic [7:0] znv(input logic [7:0] s, res,
			input logic v);
		logic [7:0] o;
		o = s;
		o[SR_Z] = (res == 8'h00);
		o[SR_N] = res[7];
		o[SR_V] = v;
		return o;
	endfunction : znv

	function automatic logic [7:0] arith(input logic [7:0] s,
			input mab_alu_t r);
		logic [7:0] o;
		o = znv(s, r.res, r.v);
		o[SR_C] = r.c;
		o[SR_H] = r.h;
		return o;
	endfunction : arith

	function automatic logic [16:0] mul(input logic [7:0] x, y,
			input logic sx, sy, fr);
		logic signed [17:0] p;
		p = $signed({sx & x[7], x}) * $signed({sy & y[7], y});
		// carry is taken before the fractional shift
		return {p[15], fr ? {p[14:0], 1'b0} : p[15:0]};
	endfunction : mul

	function automatic logic is32(input logic [15:0] x);
		return (x[15:10] == 6'b100100 && x[3:0] == 4'h0) ||
			(x[15:9] == 7'b1001010 && x[3:2] == 2'b11);
	endfunction : is32

	assign w        = instr_word;
	assign take     = ready_q & instr_valid;
	assign rd5      = w[8:4];
	assign rr5      = {w[9], w[3:0]};
	assign rdh      = {1'b1, w[7:4]};
	assign k8       = {w[11:8], w[3:0]};
	assign nx_two   = is32(instr_next);
	assign ptr      = {rf_q[PTR_HI_REG], rf_q[PTR_LO_REG]};
	assign rel_tgt  = pc_q + {{4{w[11]}}, w[11:0]} + 16'h0001;
	assign wa       = {2'b11, w[5:4], 1'b0};
	assign wv       = {rf_q[wa | 5'h01], rf_q[wa]};
	assign rdv      = rd_int_q ? flags_q : dbus_rdata;
	assign skip_hit = (rdv[rd_bit_q] == rd_hi_q);

	always_comb begin
		we0 = 1'b0;
		a0 = rd5;
		d0 = 8'h00;
		we1 = 1'b0;
		a1 = rd5;
		d1 = 8'h00;
		sr_d = sreg_q;
		pc_d = pc_q + 16'h0001;
		cyc = CYC_ALU;
		bus_d = '0;
		rd_go = 1'b0;
		rd_load = 1'b0;
		rd_skip = 1'b0;
		rd_int = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		push_v = pc_q + 16'h0001;
		fclr = 8'h00;
		al = '0;
		mp = '0;
		wr = 16'h0000;
		{op_byte, op_minus_const_with_carry, op_logic, op_word, op_mul} = '0;
		{op_relative_subroutine_jump, op_pointer_jump, op_pointer_subroutine_jump, op_jmp, op_call} = '0;
		{op_compare_equal_skip, op_bitw, op_port, op_ds} = '0;
		casez (w)
		16'b1001010100001000: begin
			pop = 1'b1;
			pc_d = stk_q[sp_q - 1'b1];
			cyc = CYC_RET;
		end
		16'b1001010000001001: begin
			op_pointer_jump = 1'b1;
			pc_d = ptr;
			cyc = CYC_POINTER_JUMP;
		end
		16'b1001010100001001: begin
			op_pointer_subroutine_jump = 1'b1;
			push = 1'b1;
			pc_d = ptr;
			cyc = CYC_POINTER_SUBROUTINE_JUMP;
		end
		16'b1001010?????110?: begin
			op_jmp = 1'b1;
			pc_d = instr_next;
			cyc = CYC_JMP;
		end
		16'b1001010?????111?: begin
			op_call = 1'b1;
			push = 1'b1;
			push_v = pc_q + 16'h0002;
			pc_d = instr_next;
			cyc = CYC_CALL;
		end
		16'b1100_????_????_????: begin
			pc_d = rel_tgt;
			cyc = CYC_RJMP;
		end
		16'b1101_????_????_????: begin
			op_relative_subroutine_jump = 1'b1;
			push = 1'b1;
			pc_d = rel_tgt;
			cyc = CYC_RELATIVE_SUBROUTINE_JUMP;
		end
		16'b000?_1???_????_????: begin
			op_byte = 1'b1;
			al = w[10] ?
				add8(rf_q[rd5], rf_q[rr5], w[12] & sreg_q[SR_C]) :
				sub8(rf_q[rd5], rf_q[rr5], ~w[12] & sreg_q[SR_C]);
			we0 = 1'b1;
			d0 = al.res;
			sr_d = arith(sreg_q, al);
		end
		16'b0001_00??_????_????: begin
			op_compare_equal_skip = 1'b1;
			if (rf_q[rd5] == rf_q[rr5]) begin
				pc_d = pc_q + {14'h0000, 1'b1, nx_two};
				cyc = nx_two ? CYC_SKIP2 : CYC_SKIP1;
			end
		end
		16'b0010_????_????_????: begin
			we0 = 1'b1;
			if (w[11:10] == 2'b11) begin
				d0 = rf_q[rr5];
			end else begin
				op_logic = 1'b1;
				d0 = w[11] ? rf_q[rd5] | rf_q[rr5] :
					w[10] ? rf_q[rd5] ^ rf_q[rr5] : rf_q[rd5] & rf_q[rr5];
				sr_d = znv(sreg_q, d0, 1'b0);
			end
		end
		16'b01??_????_????_????: begin
			we0 = 1'b1;
			a0 = rdh;
			if (!w[13]) begin
				op_minus_const_with_carry = ~w[12];
				al = sub8(rf_q[rdh], k8, ~w[12] & sreg_q[SR_C]);
				d0 = al.res;
				sr_d = arith(sreg_q, al);
			end else begin
				op_logic = 1'b1;
				d0 = w[12] ? rf_q[rdh] & k8 : rf_q[rdh] | k8;
				sr_d = znv(sreg_q, d0, 1'b0);
			end
		end
		16'b1001_011?_????_????: begin
			op_word = 1'b1;
			wr = w[8] ? wv - {10'h000, w[7:6], w[3:0]} :
				wv + {10'h000, w[7:6], w[3:0]};
			we0 = 1'b1;
			a0 = wa;
			d0 = wr[7:0];
			we1 = 1'b1;
			a1 = wa | 5'h01;
			d1 = wr[15:8];
			sr_d[SR_Z] = (wr == 16'h0000);
			sr_d[SR_N] = wr[15];
			sr_d[SR_V] = w[8] ? wv[15] & ~wr[15] : ~wv[15] & wr[15];
			sr_d[SR_C] = w[8] ? wr[15] & ~wv[15] : ~wr[15] & wv[15];
			sr_d[SR_S] = sr_d[SR_N] ^ sr_d[SR_V];
			cyc = CYC_WORD;
		end
		16'b1001_11??_????_????: begin
			op_mul = 1'b1;
			mp = mul(rf_q[rd5], rf_q[rr5], 1'b0, 1'b0, 1'b0);
		end
		16'b0000_0010_????_????: begin
			op_mul = 1'b1;
			mp = mul(rf_q[rdh], rf_q[{1'b1, w[3:0]}], 1'b1, 1'b1, 1'b0);
		end
		16'b0000_0011_????_????: begin
			op_mul = 1'b1;
			mp = mul(rf_q[{2'b10, w[6:4]}], rf_q[{2'b10, w[2:0]}],
				w[7] | ~w[3], w[7] & ~w[3], w[7] | w[3]);
		end
		16'b1001_10??_????_????: begin
			// 5-bit field: bit access cannot leave io 0x00-0x1F
			bus_d.addr = {11'h000, w[7:3]} + IO_DS_OFFSET;
			if (!w[8]) begin
				op_bitw = 1'b1;
				bus_d.wmask = 8'h01 << w[2:0];
				bus_d.wdata = w[9] ? bus_d.wmask : 8'h00;
				bus_d.we = 1'b1;
				cyc = CYC_BITIO;
			end else begin
				bus_d.re = 1'b1;
				rd_go = 1'b1;
				rd_skip = 1'b1;
			end
		end
		16'b1011_????_????_????: begin
			op_port = 1'b1;
			bus_d.addr = {10'h000, w[10:9], w[3:0]} + IO_DS_OFFSET;
			if (w[11]) begin
				bus_d.wdata = rf_q[rd5];
				bus_d.wmask = 8'hFF;
				bus_d.we = 1'b1;
			end else begin
				bus_d.re = 1'b1;
				rd_go = 1'b1;
				rd_load = 1'b1;
			end
		end
		16'b100100??????0000: begin
			// only this path reaches the extended io area
			op_ds = 1'b1;
			pc_d = pc_q + 16'h0002;
			cyc = CYC_DS;
			if (instr_next <= RF_DS_LAST) begin
				we0 = ~w[9];
				d0 = rf_q[instr_next[4:0]];
				we1 = w[9];
				a1 = instr_next[4:0];
				d1 = rf_q[rd5];
			end else begin
				bus_d.addr = instr_next;
				bus_d.wdata = rf_q[rd5];
				bus_d.wmask = {8{w[9]}};
				bus_d.we = w[9];
				bus_d.re = ~w[9];
				rd_go = ~w[9];
				rd_load = ~w[9];
			end
		end
		16'b1110????????????: begin
			// constant load into the upper half, flags untouched
			we0 = 1'b1;
			a0 = rdh;
			d0 = k8;
		end
		default: begin
		end
		endcase
		if (op_mul) begin
			we0 = 1'b1;
			a0 = 5'h00;
			d0 = mp[7:0];
			we1 = 1'b1;
			a1 = 5'h01;
			d1 = mp[15:8];
			sr_d[SR_C] = mp[16];
			sr_d[SR_Z] = (mp[15:0] == 16'h0000);
			cyc = CYC_MUL;
		end
		// the flag register lives here, so its strobes stay off the bus
		if (bus_d.addr == {11'h000, FLAG_IO_ADDR} + IO_DS_OFFSET) begin
			if (bus_d.we)
				fclr = bus_d.wdata & bus_d.wmask;
			rd_int = bus_d.re;
			bus_d.we = 1'b0;
			bus_d.re = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q <= ST_EXEC;
			ready_q <= 1'b1;
			pc_q <= PC_RST;
			wait_q <= 2'h0;
			{rd_load_q, rd_skip_q, rd_hi_q, rd_two_q, rd_int_q} <= '0;
			rd_reg_q <= 5'h00;
			rd_bit_q <= 3'h0;
		end else if (ce) begin
			case (st_q)
			ST_EXEC: begin
				if (take) begin
					pc_q <= pc_d;
					rd_load_q <= rd_load;
					rd_skip_q <= rd_skip;
					rd_hi_q <= w[9];
					rd_two_q <= nx_two;
					rd_int_q <= rd_int;
					rd_reg_q <= rd5;
					rd_bit_q <= w[2:0];
					if (rd_go) begin
						st_q <= ST_RDCAP;
						ready_q <= 1'b0;
					end else if (cyc != CYC_ALU) begin
						st_q <= ST_WAIT;
						ready_q <= 1'b0;
						wait_q <= 2'(cyc - 3'h2);
					end
				end
			end
			ST_WAIT: begin
				if (wait_q == 2'h0) begin
					st_q <= ST_EXEC;
					ready_q <= 1'b1;
				end else begin
					wait_q <= wait_q - 2'h1;
				end
			end
			ST_RDCAP: begin
				if (rd_skip_q && skip_hit) begin
					pc_q <= pc_q + {14'h0000, rd_two_q, ~rd_two_q};
					wait_q <= {1'b0, rd_two_q};
					st_q <= ST_WAIT;
				end else begin
					st_q <= ST_EXEC;
					ready_q <= 1'b1;
				end
			end
			default: begin
				st_q <= ST_EXEC;
				ready_q <= 1'b1;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < 32; i++)
				rf_q[i] <= 8'h00;
		end else if (ce) begin
			if (take && we0)
				rf_q[a0] <= d0;
			if (take && we1)
				rf_q[a1] <= d1;
			if (st_q == ST_RDCAP && rd_load_q)
				rf_q[rd_reg_q] <= rdv;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			sreg_q <= SREG_RST;
		else if (ce && take)
			sreg_q <= sr_d;
	end

	// return stack wraps silently when over- or under-run
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sp_q <= '0;
			for (int i = 0; i < STACK_DEPTH; i++)
				stk_q[i] <= 16'h0000;
		end else if (ce && take) begin
			if (push) begin
				stk_q[sp_q] <= push_v;
				sp_q <= sp_q + 1'b1;
			end else if (pop) begin
				sp_q <= sp_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			dbus_q <= '0;
		else if (ce)
			dbus_q <= take ? bus_d : '0;
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rstn)
			flags_q <= FLAGS_RST;
		else if (ce)
			flags_q <= (flags_q & ~(take ? fclr : 8'h00)) | flag_evt;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn || !ce);

	sequence s_busy1;
		!ready_q ##1 ready_q;
	endsequence
	sequence s_busy2;
		!ready_q [*2] ##1 ready_q;
	endsequence
	sequence s_busy3;
		!ready_q [*3] ##1 ready_q;
	endsequence

	a_byte_add_sub: assert property (take && op_byte |=>
		ready_q && sreg_q[SR_Z] == ($past(d0) == 8'h00))
		else $error("byte add/sub timing or zero flag wrong");
	a_imm_carry_sub: assert property (take && op_minus_const_with_carry |=>
		ready_q && rf_q[$past(a0)] == $past(d0) &&
		sreg_q[SR_H] == $past(al.h))
		else $error("subtract constant with carry wrong");
	a_word_imm: assert property (take && op_word |=>
		s_busy1 and (sreg_q[SR_S] == (sreg_q[SR_N] ^ sreg_q[SR_V])))
		else $error("word immediate op wrong");
	a_logic_flags: assert property (take && op_logic |=>
		ready_q && !sreg_q[SR_V] && $stable(sreg_q[SR_C]))
		else $error("logic op flags or timing wrong");
	a_mul_product: assert property (take && op_mul |=>
		(sreg_q[SR_Z] == ({rf_q[1], rf_q[0]} == 16'h0000)) ##0 s_busy1)
		else $error("multiply result or timing wrong");
	a_rel_call: assert property (take && op_relative_subroutine_jump |=>
		(pc_q == $past(rel_tgt)) ##0 s_busy2)
		else $error("relative call target or timing wrong");
	a_ptr_jump: assert property (take && op_pointer_jump |=>
		(pc_q == $past(ptr)) ##0 s_busy1)
		else $error("pointer jump wrong");
	a_ptr_call: assert property (take && op_pointer_subroutine_jump |=>
		(pc_q == $past(ptr)) ##0 s_busy2)
		else $error("pointer call wrong");
	a_abs_jump: assert property (take && op_jmp |=> s_busy2)
		else $error("absolute jump timing wrong");
	a_abs_call: assert property (take && op_call |=> s_busy3)
		else $error("absolute call timing wrong");
	a_compare_equal_skip_noskip: assert property (take && op_compare_equal_skip && cyc == CYC_ALU |=>
		ready_q && pc_q == $past(pc_q) + 16'h0001)
		else $error("compare skip without match wrong");
	a_bit_single: assert property (take && op_bitw && bus_d.we |=>
		dbus_q.we && $onehot(dbus_q.wmask) && dbus_q.addr <= BIT_IO_LAST)
		else $error("bit write not single bit in low io");
	a_port_offset: assert property (take && op_port &&
		(bus_d.we || bus_d.re) |=>
		dbus_q.addr == {10'h000, $past(w[10:9]), $past(w[3:0])} + IO_DS_OFFSET)
		else $error("port address offset wrong");
	a_ext_io_path: assert property ((dbus_q.we || dbus_q.re) &&
		dbus_q.addr >= EXT_IO_FIRST |-> $past(op_ds))
		else $error("extended io reached by a non data-space op");
	a_flag_w1c: assert property (take && fclr != 8'h00 |=>
		(flags_q & $past(fclr)) == ($past(flag_evt) & $past(fclr)))
		else $error("flag clear by writing one wrong");
endmodule : mab_core
`default_nettype wire

// file: core/mab_pkg.sv
// package: constants and types of the alu, branch and io access core
package mab_pkg;
	localparam logic [15:0] PC_RST       = 16'h0000;
	localparam logic [7:0]  SREG_RST     = 8'h00;
	localparam logic [7:0]  FLAGS_RST    = 8'h00;
	localparam logic [15:0] IO_DS_OFFSET = 16'h0020;
	localparam logic [15:0] RF_DS_LAST   = 16'h001F;
	localparam logic [15:0] BIT_IO_LAST  = 16'h003F;
	localparam logic [15:0] EXT_IO_FIRST = 16'h0060;
	localparam logic [4:0]  FLAG_IO_ADDR = 5'h0E;
	localparam logic [4:0]  PTR_LO_REG   = 5'h1E;
	localparam logic [4:0]  PTR_HI_REG   = 5'h1F;
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_V = 3;
	localparam int SR_S = 4;
	localparam int SR_H = 5;
	localparam logic [2:0] CYC_ALU   = 3'h1;
	localparam logic [2:0] CYC_WORD  = 3'h2;
	localparam logic [2:0] CYC_MUL   = 3'h2;
	localparam logic [2:0] CYC_RJMP  = 3'h2;
	localparam logic [2:0] CYC_POINTER_JUMP  = 3'h2;
	localparam logic [2:0] CYC_RELATIVE_SUBROUTINE_JUMP = 3'h3;
	localparam logic [2:0] CYC_POINTER_SUBROUTINE_JUMP = 3'h3;
	localparam logic [2:0] CYC_JMP   = 3'h3;
	localparam logic [2:0] CYC_CALL  = 3'h4;
	localparam logic [2:0] CYC_RET   = 3'h4;
	localparam logic [2:0] CYC_BITIO = 3'h2;
	localparam logic [2:0] CYC_DS    = 3'h2;
	localparam logic [2:0] CYC_SKIP1 = 3'h2;
	localparam logic [2:0] CYC_SKIP2 = 3'h3;
	typedef enum logic [2:0] {
		ST_EXEC  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_RDCAP = 3'b100
	} mab_state_t;
	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       h;
		logic       v;
	} mab_alu_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  wmask;
		logic        we;
		logic        re;
	} mab_bus_t;
endpackage : mab_pkg

// file: test/mab_mem_model.sv
// partner model: program memory and io/data space seen by the core
`timescale 1ns/1ps
`default_nettype none
module mab_mem_model
	import mab_pkg::*;
(
	// clock
	input  wire logic        clk,
	// instruction side
	input  wire logic [15:0] pc,
	output logic             valid,
	output logic [15:0]      word,
	output logic [15:0]      next,
	// data side
	input  var mab_bus_t     bus,
	output logic [7:0]       rdata
);
	logic [15:0] rom [0:255];
	logic [7:0]  io  [0:255];
	logic [7:0]  last_q;

	// unused program words loop on themselves so a stray jump hangs visibly
	initial begin
		for (int i = 0; i < 256; i++) begin
			rom[i] = 16'hCFFF;
			io[i]  = 8'h00;
		end
		last_q = 8'h00;
	end

	assign valid = 1'b1;
	assign word  = rom[pc[7:0]];
	assign next  = rom[pc[7:0] + 8'h01];
	// outside a read the line shows junk, never the last byte
	assign rdata = bus.re ? io[bus.addr[7:0]] : ~last_q;

	always @(posedge clk) begin
		if (bus.re) begin
			last_q <= io[bus.addr[7:0]];
		end
		if (bus.we) begin
			io[bus.addr[7:0]] <= (io[bus.addr[7:0]] & ~bus.wmask)
				| (bus.wdata & bus.wmask);
		end
	end
endmodule : mab_mem_model
`default_nettype wire

// file: test/mcu_core_alu_branch_io_access_tb.sv
// testbench: runs short programs through the core and checks the results
`timescale 1ns/1ps
`default_nettype none
module mcu_core_alu_branch_io_access_tb
	import mab_pkg::*;
;
	logic        clk;
	logic        rstn;
	logic        ce;
	logic [7:0]  flag_evt;
	logic        instr_valid;
	logic [15:0] instr_word;
	logic [15:0] instr_next;
	logic        ready_q;
	logic [15:0] pc_q;
	logic [7:0]  sreg_q;
	mab_bus_t    dbus_q;
	logic [7:0]  dbus_rdata;
	logic [7:0]  flags_q;
	logic [15:0] prog [$];
	int          n_errors;
	int          samples_checked;

	mab_core #(.STACK_DEPTH(8)) uut (
		.clk        (clk),
		.rstn       (rstn),
		.ce         (ce),
		.instr_valid(instr_valid),
		.instr_word (instr_word),
		.instr_next (instr_next),
		.ready_q    (ready_q),
		.pc_q       (pc_q),
		.sreg_q     (sreg_q),
		.dbus_q     (dbus_q),
		.dbus_rdata (dbus_rdata),
		.flag_evt   (flag_evt),
		.flags_q    (flags_q)
	);

	mab_mem_model mdl (
		.clk  (clk),
		.pc   (pc_q),
		.valid(instr_valid),
		.word (instr_word),
		.next (instr_next),
		.bus  (dbus_q),
		.rdata(dbus_rdata)
	);

	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	// reset, load prog, count cycles until the core rests at endpc
	task automatic run(input logic [15:0] endpc, input int cyc,
			input logic [7:0] fe);
		int n;
		@(posedge clk);
		rstn <= 1'b0;
		// load only once the core sits in reset, so no stray take
		@(posedge clk);
		for (int i = 0; i < 256; i++) begin
			mdl.rom[i] = (i < prog.size()) ? prog[i] : 16'hCFFF;
		end
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			flag_evt <= (n == 0) ? fe : 8'h00;
			#1;
			n++;
		end while (!(ready_q === 1'b1 && pc_q === endpc) && n < 300);
		check(16'(n), 16'(cyc));
		check(pc_q, endpc);
		// the last store lands in the model one edge after it shows
		repeat (2) @(posedge clk);
		#1;
	endtask : run

	// programs write zero to spare bits and no reserved place
	task automatic t_add;
		prog = '{16'hE70F, 16'hE011, 16'h0F01, 16'hBD0B};
		run(16'h0004, 4, 8'h00);
		check({8'h00, sreg_q}, 16'h002C);
		check({8'h00, mdl.io[8'h4B]}, 16'h0080);
	endtask : t_add

	task automatic t_sub_carry;
		prog = '{16'hE000, 16'h5001, 16'h4F0E};
		run(16'h0003, 3, 8'h00);
		check({8'h00, sreg_q}, 16'h0002);
	endtask : t_sub_carry

	task automatic t_logic;
		prog = '{16'hE000, 16'h5001, 16'h7000};
		run(16'h0003, 3, 8'h00);
		check({8'h00, sreg_q}, 16'h0023);
	endtask : t_logic

	task automatic t_word;
		prog = '{16'hEF8F, 16'hEF9F, 16'h9601};
		run(16'h0003, 4, 8'h00);
		check({8'h00, sreg_q}, 16'h0003);
	endtask : t_word

	task automatic t_mul;
		mdl.io[8'h2A] = 8'hFF;
		prog = '{16'hE800, 16'hE012, 16'h0389, 16'hB81B, 16'hB80A};
		run(16'h0005, 6, 8'h00);
		check({8'h00, sreg_q}, 16'h0001);
		check({mdl.io[8'h2B], mdl.io[8'h2A]}, 16'hFE00);
	endtask : t_mul

	// a skipped store must leave its target untouched
	task automatic t_bits;
		mdl.io[8'h25] = 8'hA5;
		mdl.io[8'h2B] = 8'h55;
		prog = '{16'h9A29, 16'h9828, 16'h9B29, 16'hB90B, 16'h9929,
			16'h9A73};
		run(16'h0006, 11, 8'h09);
		check({8'h00, mdl.io[8'h25]}, 16'h00A6);
		check({8'h00, mdl.io[8'h2B]}, 16'h0055);
		check({8'h00, flags_q}, 16'h0001);
	endtask : t_bits

	task automatic t_space;
		mdl.io[8'h29] = 8'h01;
		mdl.io[8'h60] = 8'h83;
		prog = '{16'hB109, 16'h9110, 16'h0060, 16'h9300, 16'h0061,
			16'hBF1C};
		run(16'h0006, 7, 8'h00);
		check({8'h00, mdl.io[8'h61]}, 16'h0001);
		check({8'h00, mdl.io[8'h5C]}, 16'h0083);
	endtask : t_space

	// clock enable low must keep the flag register deaf to events
	task automatic t_freeze;
		prog = '{16'hE70F};
		run(16'h0001, 1, 8'h00);
		@(posedge clk);
		ce       <= 1'b0;
		flag_evt <= 8'h04;
		@(posedge clk);
		ce       <= 1'b1;
		flag_evt <= 8'h00;
		@(posedge clk);
		#1;
		check({8'h00, flags_q}, 16'h0000);
		@(posedge clk);
		flag_evt <= 8'h04;
		@(posedge clk);
		flag_evt <= 8'h00;
		#1;
		check({8'h00, flags_q}, 16'h0004);
	endtask : t_freeze

	task automatic t_branch;
		prog = '{16'hE0EA, 16'hE0F0, 16'hD003, 16'hCFFF, 16'hCFFF,
			16'hCFFF, 16'h9509, 16'hCFFF, 16'hCFFF, 16'hCFFF,
			16'hE1E0, 16'h9409, 16'hCFFF, 16'hCFFF, 16'hCFFF,
			16'hCFFF, 16'h940C, 16'h0012, 16'h940E, 16'h0014,
			16'hE005, 16'hE015, 16'h1301, 16'h940C, 16'h0000,
			16'h1302};
		run(16'h001A, 24, 8'h00);
		check({8'h00, sreg_q}, 16'h0000);
	endtask : t_branch

	initial begin
		n_errors        = 0;
		samples_checked = 0;
		rstn            = 1'b0;
		ce              = 1'b1;
		flag_evt        = 8'h00;
		repeat (20) @(posedge clk);
		t_add();
		t_sub_carry();
		t_logic();
		t_word();
		t_mul();
		t_bits();
		t_space();
		t_branch();
		t_freeze();
		conclude();
	end

	// the nine programs need well under 3000 cycles
	initial begin
		#50000;
		n_errors++;
		conclude();
	end
endmodule : mcu_core_alu_branch_io_access_tb
`default_nettype wire
